// >>> logic/cms_pkg.sv
// Shared constants, types and mode table for the channel mode selection block
package cms_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_INMUX = 8'h04;
  localparam logic [7:0] ADDR_PWRDN = 8'h08;
  localparam logic [7:0] ADDR_FRAMECNT = 8'h0C;
  localparam logic [7:0] ADDR_LINKEN = 8'h10;
  localparam logic [7:0] ADDR_CAL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_ROUTE = 8'h1C;
  // Widths
  localparam int MODE_W = 5;
  localparam int RFAC_W = 5;
  localparam int KCNT_W = 9;
  localparam int SEL_W = 2;
  localparam int EBLK_W = 2;
  // Field positions
  localparam int INMUX_SWAP_BIT = 0;
  localparam int INMUX_SEL_LSB = 1;
  localparam int PWRDN_A_BIT = 0;
  localparam int PWRDN_B_BIT = 1;
  localparam int LINKEN_BIT = 0;
  localparam int CAL_START_BIT = 0;
  localparam int CAL_BUSY_BIT = 0;
  localparam int CAL_PEND_BIT = 1;
  localparam int STATUS_ILV_BIT = 0;
  localparam int STATUS_DDES_BIT = 1;
  localparam int STATUS_ENC64_BIT = 2;
  localparam int STATUS_VALID_BIT = 3;
  localparam int STATUS_CFGERR_BIT = 4;
  localparam int STATUS_R_LSB = 8;
  localparam int STATUS_K_LSB = 16;
  localparam int STATUS_E_LSB = 28;
  // Reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 5'h00;
  localparam logic [7:0] FRAMECNT_RESET = 8'h1F;
  // Derived link constants
  localparam logic [KCNT_W-1:0] K_OFFSET = 9'h001;
  localparam logic [EBLK_W-1:0] E_FIXED = 2'h1;
  localparam logic [RFAC_W-1:0] R_BYPASS = 5'h01;
  // Calibration duration
  localparam int CAL_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Core input sources and single-channel input select codes
  localparam logic SRC_A = 1'h0;
  localparam logic SRC_B = 1'h1;
  typedef enum logic [SEL_W-1:0] {SEL_INPUT_A, SEL_INPUT_B, SEL_BOTH, SEL_RSVD} cms_sel_e;
  typedef struct packed {
    logic valid;
    logic interleave;
    logic enc64;
    logic [RFAC_W-1:0] rFactor;
  } cms_mode_s;
  typedef struct packed {
    logic coreAOn;
    logic coreBOn;
    logic coreASrc;
    logic coreBSrc;
    logic coreBAntiPhase;
    logic rateDouble;
    logic dualInput;
  } cms_route_s;
  typedef struct packed {
    logic [RFAC_W-1:0] pllMult;
    logic pllBypass;
    logic enc64;
    logic [KCNT_W-1:0] kFrames;
    logic [EBLK_W-1:0] eBlocks;
  } cms_link_s;
  // Known mode codes
  localparam int NUM_MODES = 4;
  localparam cms_mode_s MODE_TABLE [NUM_MODES] = '{
    '{1'h1, 1'h1, 1'h0, 5'h04}, '{1'h1, 1'h1, 1'h0, 5'h02},
    '{1'h1, 1'h0, 1'h0, 5'h04}, '{1'h1, 1'h0, 1'h0, 5'h02}};
  localparam cms_mode_s MODE_UNKNOWN = '{1'h0, 1'h0, 1'h0, 5'h04};
  // Looks up a mode code, unknown codes report invalid
  function automatic cms_mode_s modeLookup(input logic [MODE_W-1:0] code);
    cms_mode_s info;
    info = MODE_UNKNOWN;
    if (int'(code) < NUM_MODES) begin
      info = MODE_TABLE[int'(code)];
    end
    return info;
  endfunction
endpackage

// >>> logic/cms_route_decode.sv
// Combinational decoder from mode and input mux settings to core routing
`timescale 1ns/100ps
module cms_route_decode (
  input cms_pkg::cms_mode_s modeInfo,
  input wire logic swap,
  input cms_pkg::cms_sel_e sel,
  input wire logic pdA,
  input wire logic pdB,
  output cms_pkg::cms_route_s route
);
  // Dual-channel routes each input to its core; single-channel interleaves both cores
  always_comb begin
    route = '0;
    if (!modeInfo.interleave) begin
      route.coreAOn = !pdA; // [RULE_04]
      route.coreBOn = !pdB; // [RULE_04]
      route.coreASrc = swap ? cms_pkg::SRC_B : cms_pkg::SRC_A; // [RULE_02] [RULE_03]
      route.coreBSrc = swap ? cms_pkg::SRC_A : cms_pkg::SRC_B; // [RULE_02] [RULE_03]
      route.rateDouble = 1'h0; // [RULE_01]
    end else begin
      route.coreAOn = 1'h1;
      route.coreBOn = 1'h1;
      route.coreBAntiPhase = 1'h1; // [RULE_05] [RULE_08]
      route.rateDouble = 1'h1; // [RULE_05]
      case (sel)
        cms_pkg::SEL_INPUT_B: begin
          route.coreASrc = cms_pkg::SRC_B; // [RULE_06]
          route.coreBSrc = cms_pkg::SRC_B;
        end
        cms_pkg::SEL_BOTH: begin
          route.coreASrc = cms_pkg::SRC_A; // [RULE_08] [RULE_09]
          route.coreBSrc = cms_pkg::SRC_B;
          route.dualInput = 1'h1;
        end
        default: begin
          route.coreASrc = cms_pkg::SRC_A; // [RULE_06]
          route.coreBSrc = cms_pkg::SRC_A;
        end
      endcase
    end
  end
endmodule

// >>> logic/cms_cal_seq.sv
// Calibration sequencer that times one calibration run
`timescale 1ns/100ps
module cms_cal_seq #(
  parameter int CYCLES = cms_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  typedef enum logic {CAL_IDLE, CAL_RUN} cms_cal_e;
  cms_cal_e state;
  cms_cal_e next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_done;

  if (CYCLES < 1) begin
    $error("CYCLES must be at least one");
  end

  // Counts the run length and pulses done in the cycle after the final one
  always_comb begin
    next_state = state;
    next_count = count;
    next_done = 1'h0;
    case (state)
      CAL_IDLE: begin
        next_count = '0;
        if (start) begin
          next_state = CAL_RUN;
        end
      end
      CAL_RUN: begin
        next_count = count + CW'(1);
        if (count == LAST) begin
          next_state = CAL_IDLE;
          next_done = 1'h1;
        end
      end
      default: next_state = CAL_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= CAL_IDLE;
      count <= '0;
      done <= 1'h0;
    end else begin
      state <= next_state;
      count <= next_count;
      done <= next_done;
    end
  end

  assign busy = (state == CAL_RUN);
endmodule

// >>> logic/cms_mode_select.sv
// Top level of the channel mode selection block with its APB register file
`timescale 1ns/100ps
// Notes on behaviour
// (RULE_01) Dual-channel mode samples each channel at the device clock rate.
// (RULE_02) Dual-channel mode routes input A to core A and input B to core B.
// (RULE_03) Swap setting exchanges the inputs between the two channels.
// (RULE_04) In dual-channel mode either channel may power down, the other keeps sampling.
// (RULE_05) Single-channel codes interleave both cores for one stream at twice the clock.
// (RULE_06) Single-channel mode takes the input chosen by the select; input A is preferred.
// (RULE_07) Input mux changes take effect only when a calibration completes.
// (RULE_08) Dual-input interleave samples the cores in antiphase, each on its own input.
// (RULE_09) Host enters dual-input interleave with a single-channel code and select both.
// (RULE_10) Dual-input interleave leaves processing and link parameters as single-channel.
// (RULE_11) Interleave flag is one for single-channel codes, zero for dual-channel codes.
// (RULE_12) Lane bit rate is device clock times R, R taken from the mode code.
// (RULE_13) R sets the serializer PLL multiplier or selects PLL bypass.
// (RULE_14) Frames per multiframe come from the frame count field, only under 8b/10b.
// (RULE_15) Multiblocks per extended multiblock are fixed at one, only under 64b/66b.
// (RULE_16) Host keeps the link disabled while it changes link parameters.
// (RULE_17) Frame count field holds frames minus one; the device adds one.
module cms_mode_select #(
  parameter int FRAME_W = 8,
  parameter int CAL_CYC = cms_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cms_pkg::cms_route_s route,
  output cms_pkg::cms_link_s linkParams,
  output logic linkReset,
  output logic calBusy
);
  // Frame count must fit below the width of the derived frame count
  if (FRAME_W < 1 || FRAME_W >= cms_pkg::KCNT_W) begin
    $error("FRAME_W out of range");
  end
  if (CAL_CYC < 1) begin
    $error("CAL_CYC must be at least one");
  end

  // Status and route fields must not overlap and must fit the data word
  if (cms_pkg::STATUS_R_LSB + cms_pkg::RFAC_W > cms_pkg::STATUS_K_LSB) begin
    $error("R field overlaps the frame count field");
  end
  if (cms_pkg::STATUS_K_LSB + cms_pkg::KCNT_W > cms_pkg::STATUS_E_LSB) begin
    $error("Frame count field overlaps the multiblock field");
  end
  if (cms_pkg::STATUS_E_LSB + cms_pkg::EBLK_W > 32) begin
    $error("Multiblock field does not fit the data word");
  end
  if ($bits(cms_pkg::cms_route_s) > 32) begin
    $error("Route struct does not fit the data word");
  end
  // Every table entry must be reachable by some mode code
  if (cms_pkg::NUM_MODES > (1 << cms_pkg::MODE_W)) begin
    $error("Mode table larger than the code space");
  end

  logic setupPhase;
  logic accessPhase;
  logic wrEn;
  logic mapped;
  logic [31:0] readWord;
  logic [31:0] statusWord;
  logic [31:0] next_prdata;
  logic errFlag;
  logic next_errFlag;
  logic [cms_pkg::MODE_W-1:0] modeCode;
  logic [cms_pkg::MODE_W-1:0] next_modeCode;
  logic muxSwap;
  logic next_muxSwap;
  cms_pkg::cms_sel_e muxSel;
  cms_pkg::cms_sel_e next_muxSel;
  logic actSwap;
  logic next_actSwap;
  cms_pkg::cms_sel_e actSel;
  cms_pkg::cms_sel_e next_actSel;
  logic pdA;
  logic next_pdA;
  logic pdB;
  logic next_pdB;
  logic [FRAME_W-1:0] frameCount;
  logic [FRAME_W-1:0] next_frameCount;
  logic linkEnable;
  logic next_linkEnable;
  logic cfgErr;
  logic next_cfgErr;
  logic routePending;
  logic next_routePending;
  logic calStart;
  logic next_calStart;
  logic calDone;
  cms_pkg::cms_mode_s modeInfo;
  cms_pkg::cms_route_s routeDec;
  cms_pkg::cms_route_s next_route;
  cms_pkg::cms_link_s linkDerived;
  cms_pkg::cms_link_s next_linkParams;
  logic next_linkReset;

  // APB phase decode; the slave never inserts wait states
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrEn = accessPhase && pwrite;
  assign pready = accessPhase;
  assign pslverr = accessPhase && errFlag;

  // Mode table lookup for the programmed code
  assign modeInfo = cms_pkg::modeLookup(modeCode);

  // Address map membership
  always_comb begin
    case (paddr)
      cms_pkg::ADDR_MODE,
      cms_pkg::ADDR_INMUX,
      cms_pkg::ADDR_PWRDN,
      cms_pkg::ADDR_FRAMECNT,
      cms_pkg::ADDR_LINKEN,
      cms_pkg::ADDR_CAL,
      cms_pkg::ADDR_STATUS,
      cms_pkg::ADDR_ROUTE: mapped = 1'h1;
      default: mapped = 1'h0;
    endcase
  end

  // Status word shows the derived mode and the parameters the link uses
  always_comb begin
    statusWord = 32'h00000000;
    statusWord[cms_pkg::STATUS_ILV_BIT] = modeInfo.interleave; // [RULE_11]
    statusWord[cms_pkg::STATUS_DDES_BIT] = route.dualInput;
    statusWord[cms_pkg::STATUS_ENC64_BIT] = modeInfo.enc64;
    statusWord[cms_pkg::STATUS_VALID_BIT] = modeInfo.valid;
    statusWord[cms_pkg::STATUS_CFGERR_BIT] = cfgErr;
    statusWord[cms_pkg::STATUS_R_LSB +: cms_pkg::RFAC_W] = modeInfo.rFactor; // [RULE_12]
    statusWord[cms_pkg::STATUS_K_LSB +: cms_pkg::KCNT_W] = linkParams.kFrames;
    statusWord[cms_pkg::STATUS_E_LSB +: cms_pkg::EBLK_W] = linkParams.eBlocks;
  end

  // Read data selection, captured in the setup phase
  always_comb begin
    readWord = 32'h00000000;
    case (paddr)
      cms_pkg::ADDR_MODE: readWord[cms_pkg::MODE_W-1:0] = modeCode;
      cms_pkg::ADDR_INMUX: begin
        readWord[cms_pkg::INMUX_SWAP_BIT] = muxSwap;
        readWord[cms_pkg::INMUX_SEL_LSB +: cms_pkg::SEL_W] = muxSel;
      end
      cms_pkg::ADDR_PWRDN: begin
        readWord[cms_pkg::PWRDN_A_BIT] = pdA;
        readWord[cms_pkg::PWRDN_B_BIT] = pdB;
      end
      cms_pkg::ADDR_FRAMECNT: readWord[FRAME_W-1:0] = frameCount;
      cms_pkg::ADDR_LINKEN: readWord[cms_pkg::LINKEN_BIT] = linkEnable;
      cms_pkg::ADDR_CAL: begin
        readWord[cms_pkg::CAL_BUSY_BIT] = calBusy;
        readWord[cms_pkg::CAL_PEND_BIT] = routePending;
      end
      cms_pkg::ADDR_STATUS: readWord = statusWord;
      cms_pkg::ADDR_ROUTE: readWord = 32'(route);
      default: readWord = 32'h00000000;
    endcase
  end

  // Bus answer registers
  always_comb begin
    next_prdata = prdata;
    next_errFlag = errFlag;
    // Taken in the setup cycle so both stand through the access cycle
    if (setupPhase) begin
      next_prdata = readWord;
      next_errFlag = !mapped;
    end
  end

  // Read data and error flag registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
      errFlag <= 1'h0;
    end else begin
      prdata <= next_prdata;
      errFlag <= next_errFlag;
    end
  end

  // Configuration registers written by software
  always_comb begin
    next_modeCode = modeCode;
    next_muxSwap = muxSwap;
    next_muxSel = muxSel;
    next_pdA = pdA;
    next_pdB = pdB;
    next_frameCount = frameCount;
    next_linkEnable = linkEnable;
    next_cfgErr = cfgErr;
    next_calStart = 1'h0;
    // Writes land at the edge that ends the access cycle
    if (wrEn) begin
      case (paddr)
        cms_pkg::ADDR_MODE: next_modeCode = pwdata[cms_pkg::MODE_W-1:0];
        cms_pkg::ADDR_INMUX: begin
          next_muxSwap = pwdata[cms_pkg::INMUX_SWAP_BIT];
          next_muxSel = cms_pkg::cms_sel_e'(pwdata[cms_pkg::INMUX_SEL_LSB +: cms_pkg::SEL_W]);
        end
        cms_pkg::ADDR_PWRDN: begin
          next_pdA = pwdata[cms_pkg::PWRDN_A_BIT];
          next_pdB = pwdata[cms_pkg::PWRDN_B_BIT];
        end
        cms_pkg::ADDR_FRAMECNT: next_frameCount = pwdata[FRAME_W-1:0];
        cms_pkg::ADDR_LINKEN: next_linkEnable = pwdata[cms_pkg::LINKEN_BIT];
        cms_pkg::ADDR_CAL: next_calStart = pwdata[cms_pkg::CAL_START_BIT] && !calBusy;
        cms_pkg::ADDR_STATUS: begin
          if (pwdata[cms_pkg::STATUS_CFGERR_BIT]) begin
            next_cfgErr = 1'h0;
          end
        end
        default: next_calStart = 1'h0;
      endcase
      // Link parameter change while enabled is flagged; the set wins over the clear
      if (linkEnable && (paddr == cms_pkg::ADDR_MODE || paddr == cms_pkg::ADDR_FRAMECNT)) begin
        next_cfgErr = 1'h1; // [RULE_16]
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeCode <= cms_pkg::MODE_RESET;
      muxSwap <= 1'h0;
      muxSel <= cms_pkg::SEL_INPUT_A;
      pdA <= 1'h0;
      pdB <= 1'h0;
      frameCount <= FRAME_W'(cms_pkg::FRAMECNT_RESET);
      linkEnable <= 1'h0;
      cfgErr <= 1'h0;
      calStart <= 1'h0;
    end else begin
      modeCode <= next_modeCode;
      muxSwap <= next_muxSwap;
      muxSel <= next_muxSel;
      pdA <= next_pdA;
      pdB <= next_pdB;
      frameCount <= next_frameCount;
      linkEnable <= next_linkEnable;
      cfgErr <= next_cfgErr;
      calStart <= next_calStart;
    end
  end

  // Calibration run timer
  cms_cal_seq #(
    .CYCLES(CAL_CYC)
  ) u_cal (
    .clk(clk),
    .reset_n(reset_n),
    .start(calStart),
    .busy(calBusy),
    .done(calDone)
  );

  // Pending mux settings become active only at calibration completion
  always_comb begin
    next_actSwap = actSwap;
    next_actSel = actSel;
    next_routePending = routePending;
    if (calDone) begin
      next_actSwap = muxSwap; // [RULE_07]
      next_actSel = muxSel; // [RULE_07]
      next_routePending = 1'h0;
    end
    // A mux change in the completion cycle keeps the flag set
    if (wrEn && paddr == cms_pkg::ADDR_INMUX &&
        (next_muxSwap != muxSwap || next_muxSel != muxSel)) begin
      next_routePending = 1'h1;
    end
  end

  // Active mux settings and pending flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      actSwap <= 1'h0;
      actSel <= cms_pkg::SEL_INPUT_A;
      routePending <= 1'h0;
    end else begin
      actSwap <= next_actSwap;
      actSel <= next_actSel;
      routePending <= next_routePending;
    end
  end

  // Core routing from the mode and the active mux settings
  cms_route_decode u_route (
    .modeInfo(modeInfo),
    .swap(actSwap),
    .sel(actSel),
    .pdA(pdA),
    .pdB(pdB),
    .route(routeDec)
  );

  // Link parameters derived from the mode code, blind to the dual-input option
  always_comb begin
    linkDerived.pllMult = modeInfo.rFactor; // [RULE_12] [RULE_13] [RULE_10]
    linkDerived.pllBypass = (modeInfo.rFactor == cms_pkg::R_BYPASS); // [RULE_13]
    linkDerived.enc64 = modeInfo.enc64;
    // Under 64b/66b the frame count is ignored and E is fixed
    if (modeInfo.enc64) begin
      linkDerived.kFrames = '0; // [RULE_14]
      linkDerived.eBlocks = cms_pkg::E_FIXED; // [RULE_15]
    end else begin
      linkDerived.kFrames = cms_pkg::KCNT_W'(frameCount) + cms_pkg::K_OFFSET; // [RULE_14] [RULE_17]
      linkDerived.eBlocks = '0; // [RULE_15]
    end
  end

  // Link parameters only follow while the link is disabled
  always_comb begin
    next_route = routeDec;
    next_linkParams = linkParams;
    if (!linkEnable) begin
      next_linkParams = linkDerived; // [RULE_16]
    end
    // Link held in reset while disabled or the code is unknown
    next_linkReset = !linkEnable || !modeInfo.valid;
  end

  // Registered route and link outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      route <= '0;
      linkParams <= '0;
      linkReset <= 1'h1;
    end else begin
      route <= next_route;
      linkParams <= next_linkParams;
      linkReset <= next_linkReset;
    end
  end
endmodule

// >>> bench/cms_mode_select_monitor.sv
// Port-level assertion checker for the channel mode selection block
`timescale 1ns/100ps
module cms_mode_select_monitor #(
  parameter int CAL_CYC = cms_pkg::CAL_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input cms_pkg::cms_route_s route,
  input cms_pkg::cms_link_s linkParams,
  input wire logic calBusy
);
  logic [15:0] busyCnt;
  logic [15:0] next_busyCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Length of the current calibration run
  always_comb begin
    next_busyCnt = calBusy ? busyCnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busyCnt <= 16'h0000;
    end else begin
      busyCnt <= next_busyCnt;
    end
  end
  chk_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready does not follow the access phase");
  chk_error_in_access: assert property (pslverr |-> pready)
    else $error("pslverr outside an access phase");
  chk_single_interleave: assert property (route.rateDouble && !route.dualInput |->
    route.coreAOn && route.coreBOn && route.coreBAntiPhase && route.coreASrc == route.coreBSrc)
    else $error("single-channel routing wrong");
  chk_dual_rate: assert property (!route.rateDouble |-> !route.coreBAntiPhase)
    else $error("dual-channel cores not in phase");
  chk_dual_inputs: assert property (route.coreAOn && route.coreBOn &&
    !route.rateDouble |-> route.coreASrc != route.coreBSrc)
    else $error("dual-channel cores share one input");
  chk_ddes_route: assert property (route.dualInput |-> route.rateDouble &&
    route.coreBAntiPhase && route.coreASrc != route.coreBSrc)
    else $error("dual-input interleave routing wrong");
  chk_eblk_fixed: assert property (linkParams.eBlocks ==
    (linkParams.enc64 ? cms_pkg::E_FIXED : 2'h0))
    else $error("extended multiblock count wrong");
  chk_k_ignored: assert property (linkParams.enc64 |-> linkParams.kFrames == 9'h000)
    else $error("frame count used under 64b/66b");
  chk_pll_bypass: assert property (linkParams.pllBypass ==
    (linkParams.pllMult == cms_pkg::R_BYPASS) || linkParams.pllMult == 5'h00)
    else $error("PLL bypass does not match R");
  chk_cal_length: assert property ($fell(calBusy) |-> busyCnt == 16'(CAL_CYC))
    else $error("calibration length wrong");
  chk_cal_bound: assert property (busyCnt <= 16'(CAL_CYC))
    else $error("calibration runs too long");
endmodule
bind cms_mode_select cms_mode_select_monitor #(.CAL_CYC(CAL_CYC)) cms_mode_select_monitor_inst (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .route(route), .linkParams(linkParams), .calBusy(calBusy));

// >>> bench/testbench.sv
// Self-checking bench for the channel mode selection block
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic [4:0] mode;
    logic [2:0] mux;
    logic [1:0] pd;
    logic [7:0] fc;
    logic [6:0] rt;
    logic [4:0] r;
  } cms_row_s;
  localparam int NR = 9;
  cms_row_s rows [NR] = '{'{5'h00, 3'h0, 2'h0, 8'h03, 7'h66, 5'h04},
    '{5'h01, 3'h2, 2'h0, 8'hFF, 7'h7E, 5'h02}, '{5'h00, 3'h4, 2'h0, 8'h1F, 7'h6F, 5'h04},
    '{5'h00, 3'h6, 2'h0, 8'h07, 7'h66, 5'h04}, '{5'h01, 3'h0, 2'h1, 8'h00, 7'h66, 5'h02},
    '{5'h02, 3'h0, 2'h0, 8'h0F, 7'h68, 5'h04}, '{5'h03, 3'h1, 2'h0, 8'h3F, 7'h70, 5'h02},
    '{5'h02, 3'h0, 2'h1, 8'h01, 7'h28, 5'h04}, '{5'h03, 3'h0, 2'h2, 8'h80, 7'h48, 5'h02}};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cms_pkg::cms_route_s route;
  cms_pkg::cms_link_s linkParams;
  logic linkReset;
  logic calBusy;
  logic [31:0] rdata;
  logic rerr;
  int fails = 0;
  int num_checks = 0;
  // Clock at 25 MHz
  always #20 clk = ~clk;
  cms_mode_select #(.CAL_CYC(4)) cms_mode_select_inst (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .route(route),
    .linkParams(linkParams), .linkReset(linkReset), .calBusy(calBusy));
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start calibration and wait for it to finish
  task automatic cal;
    int n;
    apb(1'b1, cms_pkg::ADDR_CAL, 32'h1);
    n = 0;
    while (calBusy !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    while (calBusy !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) begin
      fails++;
      stop_test();
    end
    repeat (2) @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    chk(route, 32'h0, "route in reset");
    chk(linkReset, 32'h1, "linkReset in reset");
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(route, 32'h66, "reset route");
    chk(linkParams.kFrames, 32'h20, "reset K");
    chk(linkParams.pllMult, 32'h4, "reset R");
    apb(1'b0, cms_pkg::ADDR_FRAMECNT, 32'h0);
    chk(rdata, 32'h1F, "frame field reset");
    for (int i = 0; i < NR; i++) begin
      apb(1'b1, cms_pkg::ADDR_MODE, {27'h0, rows[i].mode});
      apb(1'b1, cms_pkg::ADDR_INMUX, {29'h0, rows[i].mux});
      apb(1'b1, cms_pkg::ADDR_PWRDN, {30'h0, rows[i].pd});
      apb(1'b1, cms_pkg::ADDR_FRAMECNT, {24'h0, rows[i].fc});
      cal();
      chk(route, rows[i].rt, "route");
      chk(linkParams.pllMult, rows[i].r, "pll mult");
      chk(linkParams.kFrames, {1'b0, rows[i].fc} + 9'h001, "K");
      chk(linkParams.eBlocks, 32'h0, "E");
      chk(linkParams.enc64, 32'h0, "encoding");
      chk(linkParams.pllBypass, rows[i].r == cms_pkg::R_BYPASS, "pll bypass");
      apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0);
      chk(rdata[0], rows[i].mode < 5'h02, "interleave");
      chk(rdata[1], rows[i].rt[0], "dual input flag");
      chk(rdata[12:8], rows[i].r, "status R");
    end
    // Mux change waits for calibration; a start while busy is ignored
    apb(1'b1, cms_pkg::ADDR_PWRDN, 32'h0);
    apb(1'b1, cms_pkg::ADDR_INMUX, 32'h1);
    chk(route, 32'h68, "route before cal");
    apb(1'b0, cms_pkg::ADDR_CAL, 32'h0);
    chk(rdata, 32'h2, "mux pending");
    apb(1'b1, cms_pkg::ADDR_CAL, 32'h1);
    cal();
    chk(route, 32'h70, "route after cal");
    apb(1'b0, cms_pkg::ADDR_CAL, 32'h0);
    chk(rdata, 32'h0, "mux pending clear");
    // Unmapped and read-only places
    apb(1'b0, 8'h20, 32'h0);
    chk(rerr, 32'h1, "unmapped read error");
    chk(rdata, 32'h0, "unmapped read data");
    apb(1'b1, 8'h24, 32'h1);
    chk(rerr, 32'h1, "unmapped write");
    apb(1'b1, cms_pkg::ADDR_ROUTE, 32'h0);
    apb(1'b0, cms_pkg::ADDR_ROUTE, 32'h0);
    chk(rerr, 32'h0, "route register error");
    chk(rdata, 32'h70, "route register");
    // Enabled link freezes its parameters and flags changes
    apb(1'b1, cms_pkg::ADDR_LINKEN, 32'h1);
    repeat (2) @(posedge clk);
    chk(linkReset, 32'h0, "link running");
    apb(1'b1, cms_pkg::ADDR_FRAMECNT, 32'h09);
    repeat (2) @(posedge clk);
    chk(linkParams.kFrames, 32'h81, "K frozen");
    apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0);
    chk(rdata[4], 32'h1, "config error");
    apb(1'b1, cms_pkg::ADDR_STATUS, 32'h10);
    apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0);
    chk(rdata[4], 32'h0, "config error clear");
    // Unknown mode code holds the link in reset
    apb(1'b1, cms_pkg::ADDR_MODE, 32'h09);
    repeat (2) @(posedge clk);
    chk(linkReset, 32'h1, "invalid mode");
    apb(1'b0, cms_pkg::ADDR_STATUS, 32'h0);
    chk(rdata[3], 32'h0, "mode valid flag");
    // Reset in mid-run
    reset_n <= 1'b0;
    @(posedge clk);
    chk({route, linkReset, calBusy}, 32'h2, "second reset");
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(route, 32'h66, "route after reset");
    stop_test();
  end
endmodule
